// ===== design/ccpos_top.sv
// Output stage control of a capture/compare/PWM unit: mode steering, polarity, shutdown, hold, one-shot stretch
`timescale 1ns/100ps
module ccpos_top #(
	parameter bit FIRST_UNIT = 1'b1
) (
	input  wire logic                          mclk,
	input  wire logic                          arst_n,
	input  wire ccpos_pkg::ccpos_bus_s         bus,
	output      logic [ccpos_pkg::DATA_W-1:0] rdata,
	input  wire logic                          pwm_active,
	input  wire logic                          tb_tick,
	input  wire logic                          one_shot_start,
	input  wire logic                          trigger_in,
	input  wire logic                          shutdown_in,
	output      logic                          one_shot_busy,
	output      ccpos_pkg::ccpos_pins_s        pins
);

	// ****************************************
	// Registers
	// ****************************************
	localparam logic [15:0] CTL_MASK = FIRST_UNIT ? ccpos_pkg::CTL_MASK_FULL : ccpos_pkg::CTL_MASK_LITE;

	logic [15:0] ctl_r;
	logic [15:0] aux_r;
	logic [15:0] rdata_r;
	logic        triggered_r;
	logic [2:0]  osx_cnt_r;
	logic        os_busy_r;
	logic        phase_r;
	logic [2:0]  scan_idx_r;
	logic [5:0]  level_r;
	logic [5:0]  oe_n_r;

	logic        hold_bit;
	logic [2:0]  osx_val;
	logic [2:0]  mode;
	logic        pol_ace;
	logic        pol_bdf;
	logic [1:0]  ssa;
	logic [1:0]  ssb;
	logic        trig_en;
	logic [5:0]  pin_en;
	logic        holding;
	logic [5:0]  act;
	logic [15:0] status;

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			ctl_r <= ccpos_pkg::CTL_RESET;
		end else if (bus.wr && bus.addr == ccpos_pkg::OFS_OUT_CTL) begin
			ctl_r <= bus.wdata & CTL_MASK;
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			aux_r <= ccpos_pkg::AUX_RESET;
		end else if (bus.wr && bus.addr == ccpos_pkg::OFS_AUX_CTL) begin
			aux_r <= bus.wdata & ccpos_pkg::AUX_MASK;
		end
	end

	assign hold_bit = ctl_r[ccpos_pkg::POS_HOLD];
	assign osx_val  = ctl_r[ccpos_pkg::POS_OSX_LO +: 3];
	assign mode     = ctl_r[ccpos_pkg::POS_MODE_LO +: 3];
	assign pol_ace  = ctl_r[ccpos_pkg::POS_POL_ACE];
	assign pol_bdf  = ctl_r[ccpos_pkg::POS_POL_BDF];
	assign ssa      = ctl_r[ccpos_pkg::POS_SSA_LO +: 2];
	assign ssb      = ctl_r[ccpos_pkg::POS_SSB_LO +: 2];
	assign trig_en  = aux_r[ccpos_pkg::POS_TRIG_EN];
	assign pin_en   = aux_r[ccpos_pkg::POS_PIN_EN_LO +: 6];

	// ****************************************
	// Read port
	// ****************************************
	assign status = {10'h000, shutdown_in, phase_r, os_busy_r, holding, triggered_r, trig_en};

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			rdata_r <= 16'h0000;
		end else if (bus.rd) begin
			unique case (bus.addr)
				ccpos_pkg::OFS_OUT_CTL: rdata_r <= ctl_r;
				ccpos_pkg::OFS_AUX_CTL: rdata_r <= aux_r;
				ccpos_pkg::OFS_STATUS:  rdata_r <= status;
				default:                rdata_r <= 16'h0000;
			endcase
		end else begin
			rdata_r <= 16'h0000;
		end
	end

	assign rdata = rdata_r;

	// ****************************************
	// Trigger hold
	// ****************************************
	// The disarm wins over the trigger: with triggered mode off the latch clears even while trigger_in is high
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			triggered_r <= 1'b0;
		end else if (!trig_en) begin
			triggered_r <= 1'b0;
		end else if (trigger_in) begin
			triggered_r <= 1'b1;
		end
	end

	assign holding = trig_en && hold_bit && !triggered_r;

	// ****************************************
	// One-shot stretch
	// ****************************************
	// Busy for the start period plus osx_val further time-base periods
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			os_busy_r <= 1'b0;
			osx_cnt_r <= 3'h0;
		end else if (one_shot_start) begin
			os_busy_r <= 1'b1;
			osx_cnt_r <= osx_val;
		end else if (os_busy_r && tb_tick) begin
			if (osx_cnt_r == 3'h0) begin
				os_busy_r <= 1'b0;
			end else begin
				osx_cnt_r <= osx_cnt_r - 3'h1;
			end
		end
	end

	assign one_shot_busy = os_busy_r;

	// ****************************************
	// Mode steering
	// ****************************************
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			phase_r    <= 1'b0;
			scan_idx_r <= 3'h0;
		end else if (tb_tick) begin
			phase_r    <= !phase_r;
			scan_idx_r <= (scan_idx_r == ccpos_pkg::SCAN_LAST) ? 3'h0 : scan_idx_r + 3'h1;
		end
	end

	// act is the logical active state of each pin before polarity
	always_comb begin
		act = 6'h00;
		if (!FIRST_UNIT) begin
			act[0] = pwm_active;
		end else begin
			unique case (mode)
				ccpos_pkg::MODE_SINGLE:    act = {6{pwm_active}};
				ccpos_pkg::MODE_PUSH_PULL: act = {4'h0, pwm_active && !phase_r, pwm_active && phase_r};
				ccpos_pkg::MODE_HALF_BR:   act = {4'h0, !pwm_active, pwm_active};
				ccpos_pkg::MODE_BRUSH_REV: act = {4'h0, 1'b1, 1'b0} << 1 | {4'h0, pwm_active, 1'b0};
				ccpos_pkg::MODE_BRUSH_FWD: act = {2'h0, pwm_active, 2'h0, 1'b1};
				ccpos_pkg::MODE_SCAN:      act = 6'h01 << scan_idx_r & {6{pwm_active}};
				default:                   act = 6'h00;
			endcase
		end
	end

	// ****************************************
	// Pin drivers
	// ****************************************
	// Shutdown has priority over the trigger hold; output enable is active low
	for (genvar p = 0; p < ccpos_pkg::NUM_PINS; p++) begin : g_pin
		localparam bit GRP_BDF = (p % 2) == 1;
		logic        pol;
		logic [1:0]  sst;
		logic        lvl_nxt;
		logic        oe_nxt;

		assign pol = GRP_BDF ? pol_bdf : pol_ace;
		assign sst = GRP_BDF ? ssb : ssa;

		always_comb begin
			lvl_nxt = act[p] ^ pol;
			oe_nxt  = !pin_en[p] || (!FIRST_UNIT && GRP_BDF);
			if (shutdown_in && !oe_nxt) begin
				if (sst == ccpos_pkg::SD_ACTIVE) begin
					lvl_nxt = !pol;
				end else if (sst == ccpos_pkg::SD_INACTIVE) begin
					lvl_nxt = pol;
				end else begin
					oe_nxt = 1'b1;
				end
			end else if (holding) begin
				oe_nxt = 1'b1;
			end
		end

		always_ff @(posedge mclk or negedge arst_n) begin
			if (!arst_n) begin
				level_r[p] <= 1'b0;
				oe_n_r[p]  <= 1'b1;
			end else begin
				level_r[p] <= lvl_nxt;
				oe_n_r[p]  <= oe_nxt;
			end
		end
	end

	// One driver for the whole carrier, so no tool sees two writers of one struct
	assign pins = '{level: level_r, oe_n: oe_n_r};

endmodule : ccpos_top

// ===== design/ccpos_pkg.sv
// Package: register map, field layout and encodings of the PWM output stage control
package ccpos_pkg;

	// ****************************************
	// Register port
	// ****************************************
	localparam int unsigned ADDR_W = 4;
	localparam int unsigned DATA_W = 16;

	localparam logic [3:0] OFS_OUT_CTL  = 4'h0;
	localparam logic [3:0] OFS_AUX_CTL  = 4'h1;
	localparam logic [3:0] OFS_STATUS   = 4'h2;

	// ****************************************
	// Output control register fields
	// ****************************************
	localparam int unsigned POS_HOLD     = 15;
	localparam int unsigned POS_OSX_LO   = 12;
	localparam int unsigned POS_MODE_LO  = 8;
	localparam int unsigned POS_POL_ACE  = 5;
	localparam int unsigned POS_POL_BDF  = 4;
	localparam int unsigned POS_SSA_LO   = 2;
	localparam int unsigned POS_SSB_LO   = 0;

	localparam logic [15:0] CTL_RESET     = 16'h0000;
	localparam logic [15:0] CTL_MASK_FULL = 16'hF73F;
	localparam logic [15:0] CTL_MASK_LITE = 16'hF02C;

	// Auxiliary control: bit 0 triggered mode, bits 13:8 pin enables
	localparam int unsigned POS_TRIG_EN   = 0;
	localparam int unsigned POS_PIN_EN_LO = 8;
	localparam logic [15:0] AUX_RESET     = 16'h0000;
	localparam logic [15:0] AUX_MASK      = 16'h3F01;

	// ****************************************
	// Output mode codes
	// ****************************************
	localparam logic [2:0] MODE_SINGLE    = 3'b000;
	localparam logic [2:0] MODE_PUSH_PULL = 3'b001;
	localparam logic [2:0] MODE_HALF_BR   = 3'b010;
	localparam logic [2:0] MODE_BRUSH_REV = 3'b100;
	localparam logic [2:0] MODE_BRUSH_FWD = 3'b101;
	localparam logic [2:0] MODE_SCAN      = 3'b110;

	// Shutdown state codes
	localparam logic [1:0] SD_ACTIVE   = 2'b11;
	localparam logic [1:0] SD_INACTIVE = 2'b10;

	localparam int unsigned NUM_PINS  = 6;
	localparam logic [2:0]  SCAN_LAST = 3'h5;

	// ****************************************
	// Carriers
	// ****************************************
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              wr;
		logic              rd;
	} ccpos_bus_s;

	// Pin order within vectors: bit 0 = A ... bit 5 = F
	typedef struct packed {
		logic [NUM_PINS-1:0] level;
		logic [NUM_PINS-1:0] oe_n;
	} ccpos_pins_s;

endpackage : ccpos_pkg

// ===== dv/ccpos_chk.sv
// Port checker for the PWM output stage control
`timescale 1ns/100ps
module ccpos_chk #(
	parameter bit FIRST_UNIT = 1'b1
) (
	input wire logic                          mclk,
	input wire logic                          arst_n,
	input wire ccpos_pkg::ccpos_bus_s         bus,
	input wire logic [ccpos_pkg::DATA_W-1:0] rdata,
	input wire logic                          pwm_active,
	input wire logic                          tb_tick,
	input wire logic                          one_shot_start,
	input wire logic                          shutdown_in,
	input wire logic                          one_shot_busy,
	input wire ccpos_pkg::ccpos_pins_s        pins
);
	// Shadow of the output control register, kept from the writes seen
	logic [15:0] ctl_r;
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			ctl_r <= 16'h0000;
		end else if (bus.wr && bus.addr == ccpos_pkg::OFS_OUT_CTL) begin
			ctl_r <= bus.wdata & (FIRST_UNIT ? ccpos_pkg::CTL_MASK_FULL : ccpos_pkg::CTL_MASK_LITE);
		end
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (!arst_n);
	property p_rd_idle; !$past(bus.rd) |-> rdata == 16'h0000; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside read cycle");
	property p_rd_ctl; $past(bus.rd) && $past(bus.addr) == 4'h0 |-> rdata == $past(ctl_r); endproperty
	a_rd_ctl: assert property (p_rd_ctl) else $error("control readback wrong");
	property p_os_start; one_shot_start |=> one_shot_busy; endproperty
	a_os_start: assert property (p_os_start) else $error("one-shot did not start");
	property p_os_drop; $fell(one_shot_busy) |-> $past(tb_tick) && !$past(one_shot_start); endproperty
	a_os_drop: assert property (p_os_drop) else $error("one-shot ended without tick");
	property p_sd_ace; shutdown_in && ctl_r[3] |=> pins.oe_n[0] || pins.level[0] == ($past(ctl_r[2]) ^ $past(ctl_r[5]));
	endproperty
	a_sd_ace: assert property (p_sd_ace) else $error("pin A shutdown level wrong");
	property p_sd_bdf; shutdown_in && ctl_r[1:0] == 2'b11 |=> pins.oe_n[1] || pins.level[1] == !$past(ctl_r[4]);
	endproperty
	a_sd_bdf: assert property (p_sd_bdf) else $error("pin B shutdown level wrong");
	sequence s_plain; !shutdown_in && !ctl_r[15] && ctl_r[10:8] == 3'b000; endsequence
	property p_pol_ace; s_plain |=> pins.oe_n[0] || pins.level[0] == ($past(pwm_active) ^ $past(ctl_r[5])); endproperty
	a_pol_ace: assert property (p_pol_ace) else $error("pin A polarity wrong");
	property p_pol_bdf; s_plain |=> pins.oe_n[3] || pins.level[3] == ($past(pwm_active) ^ $past(ctl_r[4])); endproperty
	a_pol_bdf: assert property (p_pol_bdf) else $error("pin D polarity wrong");
	c_os: cover property (one_shot_busy ##1 !one_shot_busy);
	c_sd: cover property (shutdown_in && ctl_r[3]);
	c_rd: cover property ($past(bus.rd) && rdata != 16'h0000);
endmodule : ccpos_chk
bind ccpos_top ccpos_chk #(.FIRST_UNIT(FIRST_UNIT)) u_chk (.mclk(mclk), .arst_n(arst_n), .bus(bus), .rdata(rdata),
	.pwm_active(pwm_active), .tb_tick(tb_tick), .one_shot_start(one_shot_start), .shutdown_in(shutdown_in),
	.one_shot_busy(one_shot_busy), .pins(pins));

// ===== dv/ccpos_load.sv
// Load on the six output pins
`timescale 1ns/100ps
module ccpos_load (
	input  wire ccpos_pkg::ccpos_pins_s pins,
	output wire logic [5:0]             pad
);
	// Pull-down on every pad: an undriven pin reads low
	assign pad = pins.level & ~pins.oe_n;
endmodule : ccpos_load

// ===== dv/ccp_output_stage_control_test.sv
// Self-checking bench for the PWM output stage control
`timescale 1ns/100ps
module ccp_output_stage_control_test;
	logic mclk = 1'b0, arst_n = 1'b0, pwm = 1'b0, tick = 1'b0, start = 1'b0, trig = 1'b0, sd = 1'b0, busy;
	ccpos_pkg::ccpos_bus_s  bus = '0;
	ccpos_pkg::ccpos_pins_s pins;
	logic [15:0] rdata, rdata_lite, ctl;
	logic [5:0]  pad;
	logic [31:0] seed = 32'h0001_41AC;
	logic [5:0]  mode_tab [8] = '{6'h3F, 6'h00, 6'h01, 6'h00, 6'h06, 6'h09, 6'h00, 6'h00};
	int miscompares = 0, samples_checked = 0, k, n, c;
	always #10 mclk = ~mclk;
	ccpos_top dut (.mclk(mclk), .arst_n(arst_n), .bus(bus), .rdata(rdata), .pwm_active(pwm), .tb_tick(tick),
		.one_shot_start(start), .trigger_in(trig), .shutdown_in(sd), .one_shot_busy(busy), .pins(pins));
	// Second unit without the mode and B/D/F controls, sharing every input
	ccpos_top #(.FIRST_UNIT(1'b0)) dut_lite (.mclk(mclk), .arst_n(arst_n), .bus(bus), .rdata(rdata_lite),
		.pwm_active(pwm), .tb_tick(tick), .one_shot_start(start), .trigger_in(trig), .shutdown_in(sd),
		.one_shot_busy(), .pins());
	ccpos_load u_load (.pins(pins), .pad(pad));
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : cmp
	task automatic look(input logic [5:0] exp);
		#1 cmp({10'h000, pad}, {10'h000, exp});
		@(posedge mclk);
	endtask : look
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge mclk);
		bus.wr <= 1'b0;
		@(posedge mclk);
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [15:0] exp, input logic [15:0] exp_lite);
		bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
		@(posedge mclk);
		bus.rd <= 1'b0;
		#1 cmp(rdata, exp);
		cmp(rdata_lite, exp_lite);
		@(posedge mclk);
	endtask : rd
	initial begin
		repeat (20) @(posedge mclk);
		arst_n <= 1'b1;
		@(posedge mclk);
		rd(4'h0, 16'h0000, 16'h0000);
		rd(4'h1, 16'h0000, 16'h0000);
		ctl = 16'(rnd());
		wr(4'h0, ctl);
		rd(4'h0, ctl & ccpos_pkg::CTL_MASK_FULL, ctl & ccpos_pkg::CTL_MASK_LITE);
		rd(4'h3, 16'h0000, 16'h0000);
		$display("registers done");
		wr(4'h1, 16'h3F00);
		sd <= 1'b1;
		for (k = 0; k < 8; k++) begin
			wr(4'h0, {10'h000, k[2], k[2], k[1], k[0], k[1], k[0]});
			look(k[1] ? {6{k[0] ^ k[2]}} : 6'h00);
		end
		$display("shutdown done");
		sd <= 1'b0;
		for (k = 0; k < 4; k++) begin
			pwm <= k[0];
			wr(4'h0, {10'h000, k[1], k[1], 4'h0});
			look({6{k[0] ^ k[1]}});
		end
		for (k = 0; k < 8; k++) begin
			wr(4'h0, {5'h00, k[2:0], 8'h00});
			if (k == 1 || k == 6) begin
				#1 cmp(16'($onehot(pad)), 16'h0001);
				@(posedge mclk);
			end else look(mode_tab[k]);
		end
		$display("modes done");
		wr(4'h1, 16'h3F01);
		wr(4'h0, 16'h8000);
		look(6'h00);
		trig <= 1'b1;
		@(posedge mclk);
		trig <= 1'b0;
		repeat (2) @(posedge mclk);
		look(6'h3F);
		$display("hold done");
		for (k = 0; k < 4; k++) begin
			n = int'(rnd() & 32'h0000_0007);
			wr(4'h0, 16'(n) << 12);
			start <= 1'b1;
			@(posedge mclk);
			start <= 1'b0;
			c = 0;
			repeat (40) begin
				@(negedge mclk);
				if (busy !== 1'b1) break;
				@(posedge mclk);
				tick <= 1'b1;
				@(posedge mclk);
				tick <= 1'b0;
				c++;
			end
			cmp(16'(c), 16'(n + 1));
		end
		$display("one-shot done");
		end_sim();
	end
	task automatic end_sim();
		$display("checked %0d, unexpected %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : end_sim
endmodule : ccp_output_stage_control_test
